// ---- include/sflash_consts.svh ----
// Constants for the serial flash bus front end
`ifndef SFLASH_CONSTS_SVH
`define SFLASH_CONSTS_SVH
`define OP_WRITE_ENABLE 8'h06
`define OP_WRITE_DISABLE 8'h04
`define OP_STATUS_READ 8'h05
`define OP_STATUS_WRITE 8'h01
`define OP_SECTOR_ERASE 8'h20
`define OP_BLOCK32_ERASE 8'h52
`define OP_BLOCK64_ERASE 8'hD8
`define OP_CHIP_ERASE_A 8'h60
`define OP_CHIP_ERASE_B 8'hC7
`define OP_PAGE_PROGRAM 8'h02
`define OP_QUAD_PROGRAM 8'h38
`define OP_POWER_DOWN 8'hB9
`define OP_RELEASE 8'hAB
`define OP_READ 8'h03
`define OP_FAST_READ 8'h0B
`define OP_PARAM_READ 8'h5A
`define OP_DUAL_IO_READ 8'hBB
`define OP_DUAL_OUT_READ 8'h3B
`define OP_QUAD_IO_READ 8'hEB
`define OP_IDENT_READ 8'h9F
`define OP_MFR_ID_READ 8'h90
`define OP_MFR_ID2_READ 8'hEF
`define OP_MFR_ID4_READ 8'hDF
`define OP_AREA_ENTRY 8'hB1
`define OP_AREA_EXIT 8'hC1
`define OP_SECURITY_READ 8'h2B
`define OP_SECURITY_WRITE 8'h2F
`define OP_PROT_SELECT 8'h68
`define OP_SINGLE_LOCK 8'h36
`define OP_SINGLE_UNLOCK 8'h39
`define OP_GANG_UNLOCK 8'h98
`define SECTOR_SHIFT 12
`define BLOCK32_SHIFT 15
`define BLOCK64_SHIFT 16
`define TOP_BLOCK64 4'hF
`define BOTTOM_BLOCK64 4'h0
`endif

// ---- include/sflash_pkg.sv ----
// Types for the serial flash bus front end
package sflash_pkg;
   typedef enum logic [2:0] {
      ST_STANDBY = 3'b001,
      ST_OPCODE = 3'b010,
      ST_ACTIVE = 3'b100
   } link_state_t;
   typedef struct packed {
      logic [7:0] opcode;
      logic [23:0] addr;
   } cmd_t;
   typedef struct packed {
      logic [7:0] sector;
      logic [4:0] block32;
      logic [3:0] block64;
      logic sector_lock;
   } addr_map_t;
endpackage : sflash_pkg

// ---- core/sflash_front_end.sv ----
// Serial bus front end of a serial NOR flash
`timescale 1ns/1ps
`default_nettype none
`include "sflash_consts.svh"
module sflash_front_end
   import sflash_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic chip_sel_n,
   input wire logic serial_clk,
   input wire logic serial_in_io0,
   input wire logic pause_n,
   input wire logic busy,
   input wire logic [7:0] tx_byte,
   output logic serial_out_io1,
   output logic serial_out_oe,
   output logic tx_byte_req,
   output logic cmd_exec,
   output cmd_t cmd_out,
   output addr_map_t addr_map,
   output logic link_active,
   output logic paused
);
   // ****************************************
   // Input synchronisers
   // ****************************************
   logic [1:0] cs_sync_reg, sck_sync_reg, si_sync_reg, hold_sync_reg;
   logic cs_d_reg, sck_d_reg;
   // Two flops per pin, then one delay stage on select and clock for edge finding
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cs_sync_reg <= 2'h3;
         sck_sync_reg <= 2'h0;
         si_sync_reg <= 2'h0;
         hold_sync_reg <= 2'h3;
         cs_d_reg <= 1'b1;
         sck_d_reg <= 1'b0;
      end else begin
         cs_sync_reg <= {cs_sync_reg[0], chip_sel_n};
         sck_sync_reg <= {sck_sync_reg[0], serial_clk};
         si_sync_reg <= {si_sync_reg[0], serial_in_io0};
         hold_sync_reg <= {hold_sync_reg[0], pause_n};
         cs_d_reg <= cs_sync_reg[1];
         sck_d_reg <= sck_sync_reg[1];
      end
   end
   wire logic cs_n = cs_sync_reg[1];
   wire logic sck = sck_sync_reg[1];
   wire logic si = si_sync_reg[1];
   wire logic hold_n = hold_sync_reg[1];
   // Edges come from the synchronised level and its one-cycle delay
   wire logic cs_fall = cs_d_reg & ~cs_n;
   wire logic cs_rise = ~cs_d_reg & cs_n;
   // ****************************************
   // Pause tracking
   // ****************************************
   logic pause_reg, pause_next;
   // A change of pause level only takes effect while the clock is low
   // Select high always clears a pause, but after an abort the lockout keeps the link frozen until select falls while pause_n is high
   assign pause_next = cs_n ? 1'b0 : (sck ? pause_reg : ~hold_n);
   // Select rising while paused throws the command away and locks the link
   wire logic abort = cs_rise & pause_reg;
   logic locked_reg; // Set by an abort until select falls while pause_n is high
   wire logic link_ok = ~pause_reg & ~locked_reg;
   // Clock edges are masked while paused or locked; the delay stage keeps tracking
   wire logic sck_rise = link_ok & sck & ~sck_d_reg;
   wire logic sck_fall = link_ok & ~sck & sck_d_reg;
   // ****************************************
   // Opcode decoding
   // ****************************************
   // Opcodes followed by an output phase; release also returns an ID byte
   function automatic logic is_read_op(input logic [7:0] op);
      case (op)
         `OP_STATUS_READ, `OP_READ, `OP_FAST_READ, `OP_PARAM_READ, `OP_DUAL_IO_READ,
         `OP_DUAL_OUT_READ, `OP_QUAD_IO_READ, `OP_IDENT_READ, `OP_MFR_ID_READ,
         `OP_MFR_ID2_READ, `OP_MFR_ID4_READ, `OP_SECURITY_READ, `OP_RELEASE:
            is_read_op = 1'b1;
         default: is_read_op = 1'b0;
      endcase
   endfunction : is_read_op
   // Opcodes that only take effect when select rises on a byte boundary
   // Release sits in both lists: it answers like a read yet must end on a boundary
   function automatic logic is_mod_op(input logic [7:0] op);
      case (op)
         `OP_WRITE_ENABLE, `OP_WRITE_DISABLE, `OP_STATUS_WRITE, `OP_SECTOR_ERASE,
         `OP_BLOCK32_ERASE, `OP_BLOCK64_ERASE, `OP_CHIP_ERASE_A, `OP_CHIP_ERASE_B,
         `OP_PAGE_PROGRAM, `OP_QUAD_PROGRAM, `OP_POWER_DOWN, `OP_RELEASE, `OP_AREA_ENTRY,
         `OP_AREA_EXIT, `OP_SECURITY_WRITE, `OP_PROT_SELECT, `OP_SINGLE_LOCK,
         `OP_SINGLE_UNLOCK, `OP_GANG_UNLOCK:
            is_mod_op = 1'b1;
         default: is_mod_op = 1'b0;
      endcase
   endfunction : is_mod_op
   // Commands that touch the array or its state; refused while busy
   function automatic logic is_array_op(input logic [7:0] op);
      is_array_op = is_mod_op(op) & (op != `OP_WRITE_DISABLE);
   endfunction : is_array_op
   // ****************************************
   // Serial state machine
   // ****************************************
   // The bit counter runs through the whole frame, so a zero count at select rise
   // means the frame held a whole number of bytes
   link_state_t state_reg, state_next;
   logic [7:0] shift_reg, opcode_reg;
   logic [2:0] bit_cnt_reg;
   logic [23:0] addr_reg;
   logic [2:0] addr_bytes_reg;
   logic [7:0] out_reg;
   logic out_en_reg;
   wire logic [7:0] shift_next = {shift_reg[6:0], si};
   wire logic byte_done = sck_rise & (bit_cnt_reg == 3'h7);
   wire logic op_known = is_read_op(shift_next) | is_mod_op(shift_next);
   // A modifying command is run on select rise exactly at a byte boundary
   wire logic exec_ok = cs_rise & ~pause_reg & (state_reg == ST_ACTIVE)
      & is_mod_op(opcode_reg) & (bit_cnt_reg == 3'h0)
      & ~(busy & is_array_op(opcode_reg));
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_STANDBY: if (cs_fall) state_next = ST_OPCODE;
         ST_OPCODE: if (byte_done) state_next = op_known ? ST_ACTIVE : ST_STANDBY;
         ST_ACTIVE: state_next = ST_ACTIVE;
         default: state_next = ST_STANDBY;
      endcase
      if (cs_rise) state_next = ST_STANDBY;
   end
   // Pause, lockout and state registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pause_reg <= 1'b0;
         locked_reg <= 1'b0;
         state_reg <= ST_STANDBY;
      end else begin
         pause_reg <= pause_next;
         if (abort) locked_reg <= 1'b1;
         else if (hold_n & ~cs_n & cs_d_reg) locked_reg <= 1'b0;
         state_reg <= abort ? ST_STANDBY : state_next;
      end
   end
   // Bit shifting, address capture and byte counting
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         shift_reg <= 8'h00;
         bit_cnt_reg <= 3'h0;
         opcode_reg <= 8'h00;
         addr_reg <= 24'h000000;
         addr_bytes_reg <= 3'h0;
      end else if (cs_fall | abort) begin
         bit_cnt_reg <= 3'h0;
         addr_bytes_reg <= 3'h0;
      end else if (sck_rise & (state_reg != ST_STANDBY)) begin
         shift_reg <= shift_next;
         bit_cnt_reg <= bit_cnt_reg + 3'h1;
         if (byte_done & (state_reg == ST_OPCODE)) opcode_reg <= shift_next;
         if (byte_done & (state_reg == ST_ACTIVE) & (addr_bytes_reg != 3'h3)) begin
            addr_reg <= {addr_reg[15:0], shift_next};
            addr_bytes_reg <= addr_bytes_reg + 3'h1;
         end
      end
   end
   // ****************************************
   // Output phase
   // ****************************************
   // Read-type opcodes stay in the output phase until select rises
   wire logic out_phase = (state_reg == ST_ACTIVE) & is_read_op(opcode_reg);
   // Output changes on falling clock; undriven in standby or pause
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         out_reg <= 8'h00;
         serial_out_io1 <= 1'b0;
         serial_out_oe <= 1'b0;
         tx_byte_req <= 1'b0;
         out_en_reg <= 1'b0;
      end else begin
         tx_byte_req <= out_phase & byte_done;
         out_en_reg <= out_phase & ~cs_n;
         serial_out_oe <= out_en_reg & out_phase & ~pause_reg & ~cs_n;
         if (sck_fall & out_phase) begin
            serial_out_io1 <= (bit_cnt_reg == 3'h0) ? tx_byte[7] : out_reg[7];
            out_reg <= (bit_cnt_reg == 3'h0) ? {tx_byte[6:0], 1'b0} : {out_reg[6:0], 1'b0};
         end
      end
   end
   // ****************************************
   // Command hand-off and address map
   // ****************************************
   // The end 64 KB blocks lock per sector, the rest per block
   wire logic [3:0] blk64 = addr_reg[`BLOCK64_SHIFT +: 4];
   wire logic sect_lock = (blk64 == `TOP_BLOCK64) | (blk64 == `BOTTOM_BLOCK64);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cmd_exec <= 1'b0;
         cmd_out <= '0;
         addr_map <= '0;
         link_active <= 1'b0;
         paused <= 1'b0;
      end else begin
         cmd_exec <= exec_ok;
         if (exec_ok) cmd_out <= '{opcode: opcode_reg, addr: addr_reg};
         addr_map <= '{sector: addr_reg[`SECTOR_SHIFT +: 8],
            block32: addr_reg[`BLOCK32_SHIFT +: 5], block64: blk64, sector_lock: sect_lock};
         link_active <= (state_reg == ST_ACTIVE);
         paused <= pause_reg;
      end
   end
endmodule : sflash_front_end
`default_nettype wire

// ---- verif/sflash_front_end_monitor.sv ----
// Port checks for the flash front end
`timescale 1ns/1ps
`default_nettype none
module sflash_front_end_monitor
   import sflash_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic chip_sel_n,
   input wire logic serial_clk,
   input wire logic pause_n,
   input wire logic busy,
   input wire logic serial_out_oe,
   input wire logic cmd_exec,
   input wire cmd_t cmd_out,
   input wire addr_map_t addr_map,
   input wire logic link_active,
   input wire logic paused
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   // Pause held with select and clock low
   sequence s_hold;
      !chip_sel_n && !pause_n && !serial_clk;
   endsequence
   property p_pulse; cmd_exec |=> !cmd_exec; endproperty
   a_pulse: assert property (p_pulse) else $error("exec pulse");
   property p_busy; cmd_exec && busy |-> !(cmd_out.opcode inside {8'h02, 8'h38, 8'h20,
      8'h52, 8'hD8, 8'h60, 8'hC7}); endproperty
   a_busy: assert property (p_busy) else $error("busy exec");
   property p_map; cmd_exec && cmd_out.opcode == 8'h20 |-> addr_map.sector == cmd_out.addr[19:12]
      && addr_map.sector_lock == (cmd_out.addr[19:16] inside {4'h0, 4'hF}); endproperty
   a_map: assert property (p_map) else $error("addr map");
   property p_idle; !link_active [*3] |-> !serial_out_oe; endproperty
   a_idle: assert property (p_idle) else $error("standby drive");
   property p_hoe; paused [*3] |-> !serial_out_oe; endproperty
   a_hoe: assert property (p_hoe) else $error("pause drive");
   property p_hon; $fell(pause_n) && !chip_sel_n ##1 s_hold [*8] |-> paused; endproperty
   a_hon: assert property (p_hon) else $error("pause start");
   property p_hoff; (pause_n && !serial_clk) [*8] |-> !paused; endproperty
   a_hoff: assert property (p_hoff) else $error("pause end");
   property p_desel; chip_sel_n [*8] |-> !paused && !link_active; endproperty
   a_desel: assert property (p_desel) else $error("deselect");
endmodule : sflash_front_end_monitor
bind sflash_front_end sflash_front_end_monitor mon (.clk(clk), .rst(rst), .busy(busy),
   .chip_sel_n(chip_sel_n), .serial_clk(serial_clk), .pause_n(pause_n), .paused(paused),
   .serial_out_oe(serial_out_oe), .cmd_exec(cmd_exec), .cmd_out(cmd_out),
   .addr_map(addr_map), .link_active(link_active));
`default_nettype wire

// ---- verif/host_model.sv ----
// Serial bus host model
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input wire logic clk,
   input wire logic miso,
   input wire logic miso_oe,
   output logic cs_n,
   output logic sck,
   output logic mosi,
   output logic hold_n
);
   bit mode3;
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      mosi = 1'b0;
      hold_n = 1'b1;
   end
   // Wait n falling edges
   task automatic t(input int n);
      repeat (n) @(negedge clk);
   endtask : t
   // One frame MSB first, optional pause and abort before bit h
   task automatic frame(input logic [47:0] d, input int n, input int h, input bit ab,
         output logic [7:0] rx);
      rx = 8'h00;
      sck = mode3;
      cs_n = 1'b0;
      t(4);
      for (int i = 0; i < n; i++) begin
         sck = 1'b0;
         mosi = d[47 - i];
         if (i == h) begin
            t(1);
            hold_n = 1'b0;
            t(10);
            sck = 1'b1;
            t(2);
            sck = 1'b0;
            cs_n = ab;
            t(4);
            hold_n = 1'b1;
            t(6);
            if (ab) return;
         end
         t(4);
         sck = 1'b1;
         t(2);
         rx = {rx[6:0], miso_oe ? miso : ~rx[0]};
         t(2);
      end
      sck = mode3;
      t(2);
      cs_n = 1'b1;
      mosi = ~mosi;
      t(16);
   endtask : frame
endmodule : host_model
`default_nettype wire

// ---- verif/test_serial_flash_bus_front_end.sv ----
// Self-checking bench for the flash front end
`timescale 1ns/1ps
`default_nettype none
`define CHECK(a, b, s) begin n_compared++; if ((a) !== (b)) begin mismatches++; \
   $display("[FAIL] %0t %s", $time, s); end end
module test_serial_flash_bus_front_end;
   import sflash_pkg::*;
   logic clk, rst, busy, cs_n, sck, mosi, hold_n, so, oe, req, exec, act, pau, oe_seen;
   logic [7:0] tx_byte;
   cmd_t cmd, last;
   addr_map_t amap;
   int mismatches, n_compared, n_exec, n_req;
   logic [7:0] ops [18] = '{8'h06, 8'h04, 8'h01, 8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7, 8'h02,
      8'h38, 8'hB9, 8'hB1, 8'hC1, 8'h2F, 8'h68, 8'h36, 8'h39, 8'h98};
   int lens [18] = '{8, 8, 16, 32, 32, 32, 8, 8, 40, 40, 8, 8, 8, 8, 8, 32, 32, 8};
   sflash_front_end dut (.clk(clk), .rst(rst), .chip_sel_n(cs_n), .serial_clk(sck),
      .serial_in_io0(mosi), .pause_n(hold_n), .busy(busy), .tx_byte(tx_byte),
      .serial_out_io1(so), .serial_out_oe(oe), .tx_byte_req(req), .cmd_exec(exec),
      .cmd_out(cmd), .addr_map(amap), .link_active(act), .paused(pau));
   host_model m (.clk(clk), .miso(so), .miso_oe(oe), .cs_n(cs_n), .sck(sck),
      .mosi(mosi), .hold_n(hold_n));
   // Collect accepted commands and output activity
   always @(posedge clk) begin
      if (exec === 1'b1) begin
         n_exec++;
         last = cmd;
      end
      if (oe === 1'b1) oe_seen = 1'b1;
      if (req === 1'b1) n_req++;
   end
   // Send one frame and compare its outcome
   task automatic send(input logic [7:0] op, input int n, input int h, input bit ab,
         input bit ex);
      logic [23:0] a;
      logic [7:0] rx;
      int e, r;
      a = $urandom;
      e = n_exec;
      r = n_req;
      oe_seen = 1'b0;
      tx_byte = $urandom;
      m.mode3 = $urandom;
      m.frame({op, a, 16'h0000}, n, h, ab, rx);
      `CHECK(n_exec - e, int'(ex), "exec count")
      if (ex) `CHECK(last.opcode, op, "opcode")
      if (ex && n >= 32) `CHECK(last.addr, a, "address")
      if (op == 8'h05) `CHECK(rx, tx_byte, "read byte")
      `CHECK(oe_seen, op inside {8'h05, 8'hAB}, "drive")
      `CHECK(n_req - r, int'(op == 8'h05), "byte request")
   endtask : send
   task automatic report_and_stop;
      if (mismatches == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : report_and_stop
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      #2000000;
      mismatches++;
      report_and_stop;
   end
   // Main sequence
   initial begin
      rst = 1'b1;
      busy = 1'b0;
      tx_byte = 8'h00;
      void'($urandom(32'hDFD2));
      repeat (12) @(posedge clk);
      @(negedge clk) rst = 1'b0;
      repeat (8) @(negedge clk);
      foreach (ops[i]) send(ops[i], lens[i], 99, 1'b0, 1'b1);
      foreach (ops[i]) send(ops[i], lens[i] + 1, 99, 1'b0, 1'b0);
      send(8'hFF, 16, 99, 1'b0, 1'b0);
      send(8'hAB, 8, 99, 1'b0, 1'b1);
      send(8'hAB, 9, 99, 1'b0, 1'b0);
      repeat (4) send(8'h05, 16, 99, 1'b0, 1'b0);
      send(8'h05, 16, 12, 1'b0, 1'b0);
      busy = 1'b1;
      send(8'h20, 32, 99, 1'b0, 1'b0);
      send(8'h04, 8, 3, 1'b0, 1'b1);
      busy = 1'b0;
      send(8'h06, 8, 4, 1'b1, 1'b0);
      send(8'h06, 8, 99, 1'b0, 1'b1);
      report_and_stop;
   end
endmodule : test_serial_flash_bus_front_end
`default_nettype wire
